// File: inc/pctrim_pkg.sv
// Package for the second-bank peripheral clock gate and RC trim block.
// Assumes an APB slave with 32-bit data and byte addressing.
package pctrim_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_CLOCK_ON    = 32'h400E0500;
   localparam logic [31:0] ADDR_CLOCK_OFF   = 32'h400E0504;
   localparam logic [31:0] ADDR_CLOCK_STATE = 32'h400E0508;
   localparam logic [31:0] ADDR_RC_TRIM     = 32'h400E0510;
   localparam logic [31:0] ADDR_WRITE_LOCK  = 32'h400E04E4;
   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int          NUM_PERIPH        = 12;
   localparam logic [11:0] CLOCK_STATE_RESET = 12'h000;
   localparam logic [11:0] IMPLEMENTED_MASK  = 12'hFFF;
   localparam int          TRIM_WIDTH        = 7;
   localparam int          TRIM_LOW_POS      = 0;
   localparam int          TRIM_MID_POS      = 8;
   localparam int          TRIM_HIGH_POS     = 16;
   localparam int          TRIM_SEL_OFS      = 7;
   localparam logic [23:0] RC_TRIM_RESET     = 24'h000000;
   localparam logic [23:0] RC_TRIM_MASK      = 24'hFFFFFF;
   localparam logic [23:0] WRITE_LOCK_KEY    = 24'h504D43;
   localparam int          LOCK_KEY_POS      = 8;
   localparam logic        LOCK_EN_RESET     = 1'b0;
endpackage

// File: inc/pctrim_wr_if.sv
// Write strobe bundle from the bus decode to the register store.
// Assumes one clock domain; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface pctrim_wr_if;
   logic        onWr;
   logic        offWr;
   logic        trimWr;
   logic [31:0] wdata;
   logic [11:0] clockState;
   logic [23:0] trimReg;
   modport master (output onWr, output offWr, output trimWr, output wdata,
                   input clockState, input trimReg);
   modport store  (input onWr, input offWr, input trimWr, input wdata,
                   output clockState, output trimReg);
endinterface
`default_nettype wire

// File: rtl/pctrim_store.sv
// Register store: peripheral clock state bits and the RC trim register.
// Assumes the caller has already applied the write lock to the strobes.
`timescale 1ns/1ps
`default_nettype none
module pctrim_store (
   // Clock and reset
   input  wire logic  clk_sys,
   input  wire logic  rstn,
   // Write strobes
   pctrim_wr_if.store wr
);
   logic [11:0] clockState_next;
   logic [11:0] setBits;
   logic [11:0] clrBits;

   assign setBits = wr.onWr  ? (wr.wdata[11:0] & pctrim_pkg::IMPLEMENTED_MASK) : 12'h000;
   assign clrBits = wr.offWr ? (wr.wdata[11:0] & pctrim_pkg::IMPLEMENTED_MASK) : 12'h000;

   genvar i;
   generate
      for (i = 0; i < pctrim_pkg::NUM_PERIPH; i++) begin : g_bit
         // Ones switch, zeros leave the bit alone
         assign clockState_next[i] = setBits[i] ? 1'b1 :
                                     clrBits[i] ? 1'b0 :
                                     wr.clockState[i];
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr.clockState <= pctrim_pkg::CLOCK_STATE_RESET;
         wr.trimReg    <= pctrim_pkg::RC_TRIM_RESET;
      end else begin
         wr.clockState <= clockState_next;
         if (wr.trimWr) begin
            wr.trimReg <= wr.wdata[23:0] & pctrim_pkg::RC_TRIM_MASK;
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/pctrim_top.sv
// Second-bank peripheral clock gate and RC oscillator trim select.
// Assumes an APB master on clk_sys; factory trims arrive as stable levels.
//
// Functional notes
// - Writing one to an enable bit turns that peripheral clock on.
// - Writing one to a disable bit turns that peripheral clock off.
// - Status bits read one while the clock is on, zero when off.
// - Bits of unimplemented peripherals change nothing.
// - Disable and trim writes are ignored while the write lock is set.
// - Low trim uses bits 6..0 when bit 7 set, else factory value.
// - Mid trim uses bits 14..8 when bit 15 set, else factory value.
// - High trim uses bits 22..16 when bit 23 set, else factory value.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pctrim_top (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Factory trims from flash
   input  wire logic [6:0]  factoryTrimLow,
   input  wire logic [6:0]  factoryTrimMid,
   input  wire logic [6:0]  factoryTrimHigh,
   // Clock gates and oscillator trims
   output logic      [11:0] periphClockEn,
   output logic      [6:0]  trimLow,
   output logic      [6:0]  trimMid,
   output logic      [6:0]  trimHigh
);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   pctrim_wr_if wr ();

   logic        access;
   logic        wrAccess;
   logic        selOn;
   logic        selOff;
   logic        selState;
   logic        selTrim;
   logic        selLock;
   logic        mapped;
   logic        lockEn_reg;
   logic        keyOk;
   logic [31:0] rdataMux;
   logic [6:0]  trimLow_next;
   logic [6:0]  trimMid_next;
   logic [6:0]  trimHigh_next;

   assign access   = psel & penable;
   assign wrAccess = access & pwrite;
   assign selOn    = (paddr == pctrim_pkg::ADDR_CLOCK_ON);
   assign selOff   = (paddr == pctrim_pkg::ADDR_CLOCK_OFF);
   assign selState = (paddr == pctrim_pkg::ADDR_CLOCK_STATE);
   assign selTrim  = (paddr == pctrim_pkg::ADDR_RC_TRIM);
   assign selLock  = (paddr == pctrim_pkg::ADDR_WRITE_LOCK);
   assign mapped   = selOn | selOff | selState | selTrim | selLock;
   assign pready   = 1'b1;
   // Unmapped addresses answer with an error; writes there change nothing
   assign pslverr  = access & ~mapped;

   assign keyOk = (pwdata[31:pctrim_pkg::LOCK_KEY_POS] == pctrim_pkg::WRITE_LOCK_KEY);

   assign wr.onWr   = wrAccess & selOn;
   assign wr.offWr  = wrAccess & selOff & ~lockEn_reg;
   assign wr.trimWr = wrAccess & selTrim & ~lockEn_reg;
   assign wr.wdata  = pwdata;

   pctrim_store u_store (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .wr      (wr.store)
   );

   // ----------------------------------------------------------------
   // Write lock
   // ----------------------------------------------------------------
   // A wrong key leaves the lock as it was
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lockEn_reg <= pctrim_pkg::LOCK_EN_RESET;
      end else if (wrAccess && selLock && keyOk) begin
         lockEn_reg <= pwdata[0];
      end
   end

   // ----------------------------------------------------------------
   // Read data and trim selection
   // ----------------------------------------------------------------
   // Key field always reads as zero
   assign rdataMux = selState ? {20'h00000, wr.clockState} :
                     selTrim  ? {8'h00, wr.trimReg} :
                     selLock  ? {31'h00000000, lockEn_reg} :
                     32'h00000000;

   assign trimLow_next  = wr.trimReg[pctrim_pkg::TRIM_LOW_POS + pctrim_pkg::TRIM_SEL_OFS]
                          ? wr.trimReg[pctrim_pkg::TRIM_LOW_POS +: pctrim_pkg::TRIM_WIDTH]
                          : factoryTrimLow;
   assign trimMid_next  = wr.trimReg[pctrim_pkg::TRIM_MID_POS + pctrim_pkg::TRIM_SEL_OFS]
                          ? wr.trimReg[pctrim_pkg::TRIM_MID_POS +: pctrim_pkg::TRIM_WIDTH]
                          : factoryTrimMid;
   assign trimHigh_next = wr.trimReg[pctrim_pkg::TRIM_HIGH_POS + pctrim_pkg::TRIM_SEL_OFS]
                          ? wr.trimReg[pctrim_pkg::TRIM_HIGH_POS +: pctrim_pkg::TRIM_WIDTH]
                          : factoryTrimHigh;

   // Registered outputs keep trims glitch-free while the selector changes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prdata   <= 32'h00000000;
         trimLow  <= 7'h00;
         trimMid  <= 7'h00;
         trimHigh <= 7'h00;
      end else begin
         prdata   <= (psel & ~penable & ~pwrite) ? rdataMux : prdata;
         trimLow  <= trimLow_next;
         trimMid  <= trimMid_next;
         trimHigh <= trimHigh_next;
      end
   end

   assign periphClockEn = wr.clockState;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_on_write;
      wrAccess && selOn && pwdata[0];
   endsequence
   sequence s_off_write;
      wrAccess && selOff && pwdata[0] && !selOn;
   endsequence

   property p_on_sets;
      @(posedge clk_sys) disable iff (!rstn) s_on_write |=> periphClockEn[0];
   endproperty
   a_clock_on_set: assert property (p_on_sets) else $error("enable write lost");

   property p_off_clears;
      @(posedge clk_sys) disable iff (!rstn)
         (s_off_write and !lockEn_reg) |=> !periphClockEn[0];
   endproperty
   a_clock_off_clear: assert property (p_off_clears) else $error("disable write lost");

   a_state_reads: assert property (@(posedge clk_sys) disable iff (!rstn)
      (psel && !penable && !pwrite && selState) |=> prdata[11:0] == $past(periphClockEn))
      else $error("status read mismatch");

   a_high_bits_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      selState && access && !pwrite |-> prdata[31:12] == 20'h00000)
      else $error("unimplemented bits set");

   a_lock_blocks_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wrAccess && selOff && lockEn_reg) |=> periphClockEn == $past(periphClockEn))
      else $error("locked disable took effect");

   a_lock_blocks_trim: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wrAccess && selTrim && lockEn_reg) |=> $stable(wr.trimReg))
      else $error("locked trim write took effect");

   a_trim_low_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
      rstn |=>
         trimLow == ($past(wr.trimReg[7]) ? $past(wr.trimReg[6:0]) : $past(factoryTrimLow)))
      else $error("low trim select wrong");

   a_trim_mid_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
      rstn |=>
         trimMid == ($past(wr.trimReg[15]) ? $past(wr.trimReg[14:8]) : $past(factoryTrimMid)))
      else $error("mid trim select wrong");

   a_trim_high_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
      rstn |=>
         trimHigh == ($past(wr.trimReg[23]) ? $past(wr.trimReg[22:16]) : $past(factoryTrimHigh)))
      else $error("high trim select wrong");

   a_lock_key_only: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wrAccess && selLock && !keyOk) |=> $stable(lockEn_reg))
      else $error("lock changed without key");

   a_clock_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
      !(wr.onWr || wr.offWr) |=> $stable(periphClockEn))
      else $error("clock bit changed without write");
endmodule
`default_nettype wire

// File: verif/pctrim_tb.sv
// Self-checking bench for the clock gate and RC trim block.
// Assumes pctrim_pkg is compiled first; APB master with one idle cycle between transfers.
`timescale 1ns/1ps
`default_nettype none
module pctrim_tb;
   localparam logic [6:0] FACT_LOW  = 7'h15;
   localparam logic [6:0] FACT_MID  = 7'h2A;
   localparam logic [6:0] FACT_HIGH = 7'h4C;
   logic        clk_sys;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [6:0]  factLow;
   logic [6:0]  factMid;
   logic [6:0]  factHigh;
   logic [11:0] periphClockEn;
   logic [6:0]  trimLow;
   logic [6:0]  trimMid;
   logic [6:0]  trimHigh;
   int          failures;
   int          samplesChecked;

   pctrim_top dut_u (
      .clk_sys         (clk_sys),
      .rstn            (rstn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .factoryTrimLow  (factLow),
      .factoryTrimMid  (factMid),
      .factoryTrimHigh (factHigh),
      .periphClockEn   (periphClockEn),
      .trimLow         (trimLow),
      .trimMid         (trimMid),
      .trimHigh        (trimHigh)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("failures=%0d samples_checked=%0d", failures, samplesChecked);
      if (failures == 0 && samplesChecked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Read data is only compared on reads; the error flag on every transfer
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] expRd, input logic expErr);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // The wait for the answer ends on pready; only the watchdog ends one that never sees it
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      if (!w) chk(prdata, expRd);
      chk({31'h0, pslverr}, {31'h0, expErr});
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Trims are registered once more behind the register, so two edges settle all
   task automatic outs(input logic [11:0] en, input logic [6:0] lo, input logic [6:0] mi,
                       input logic [6:0] hi);
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1;
      chk({20'h0, periphClockEn}, {20'h0, en});
      chk({25'h0, trimLow}, {25'h0, lo});
      chk({25'h0, trimMid}, {25'h0, mi});
      chk({25'h0, trimHigh}, {25'h0, hi});
   endtask

   // ----------------------------------------------------------------
   // Clock, reset and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      failures = 0;
      samplesChecked = 0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      factLow = FACT_LOW;
      factMid = FACT_MID;
      factHigh = FACT_HIGH;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      outs(12'h000, FACT_LOW, FACT_MID, FACT_HIGH);
      apb(1'b0, pctrim_pkg::ADDR_CLOCK_STATE, 32'h0, 32'h0, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_ON, 32'hFFFFF00A, 32'h0, 1'b0);
      outs(12'h00A, FACT_LOW, FACT_MID, FACT_HIGH);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_ON, 32'h00000F00, 32'h0, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_ON, 32'h0, 32'h0, 1'b0);
      outs(12'hF0A, FACT_LOW, FACT_MID, FACT_HIGH);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_OFF, 32'hFFFFF102, 32'h0, 1'b0);
      outs(12'hE08, FACT_LOW, FACT_MID, FACT_HIGH);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_STATE, 32'hFFFFFFFF, 32'h0, 1'b0);
      apb(1'b0, pctrim_pkg::ADDR_CLOCK_STATE, 32'h0, 32'h00000E08, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_RC_TRIM, 32'h00A23385, 32'h0, 1'b0);
      factMid <= 7'h59;
      outs(12'hE08, 7'h05, 7'h59, 7'h22);
      apb(1'b0, pctrim_pkg::ADDR_RC_TRIM, 32'h0, 32'h00A23385, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_RC_TRIM, 32'h0033B333, 32'h0, 1'b0);
      factLow  <= 7'h6A;
      factHigh <= 7'h3C;
      outs(12'hE08, 7'h6A, 7'h33, 7'h3C);
      apb(1'b1, pctrim_pkg::ADDR_WRITE_LOCK, 32'h12345601, 32'h0, 1'b0);
      apb(1'b0, pctrim_pkg::ADDR_WRITE_LOCK, 32'h0, 32'h0, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_OFF, 32'h00000008, 32'h0, 1'b0);
      outs(12'hE00, 7'h6A, 7'h33, 7'h3C);
      apb(1'b1, pctrim_pkg::ADDR_WRITE_LOCK, {pctrim_pkg::WRITE_LOCK_KEY, 8'h01}, 32'h0, 1'b0);
      apb(1'b0, pctrim_pkg::ADDR_WRITE_LOCK, 32'h0, 32'h00000001, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_OFF, 32'h00000E00, 32'h0, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_RC_TRIM, 32'h00808080, 32'h0, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_ON, 32'h00000001, 32'h0, 1'b0);
      outs(12'hE01, 7'h6A, 7'h33, 7'h3C);
      apb(1'b0, pctrim_pkg::ADDR_RC_TRIM, 32'h0, 32'h0033B333, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_WRITE_LOCK, {pctrim_pkg::WRITE_LOCK_KEY, 8'h00}, 32'h0, 1'b0);
      apb(1'b1, pctrim_pkg::ADDR_CLOCK_OFF, 32'h00000001, 32'h0, 1'b0);
      apb(1'b1, 32'h400E0600, 32'h00000FFF, 32'h0, 1'b1);
      apb(1'b0, 32'h400E0600, 32'h0, 32'h0, 1'b1);
      outs(12'hE00, 7'h6A, 7'h33, 7'h3C);
      print_verdict();
   end
endmodule
`default_nettype wire
